// ===== pkg/pwg_pkg.sv
package pwg_pkg;

    // ==========================================
    // timing
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned REF_HZ = 100_000_000;
    localparam int unsigned PWM_MAX_REF_HZ = 193_000;
    localparam int unsigned PWM_MAX_HZ =
        32'(64'(PWM_MAX_REF_HZ) * 64'(CLK_HZ) / 64'(REF_HZ));
    localparam int unsigned PWM_MIN_HZ = 1;
    localparam int unsigned PDM_MAX_HZ = CLK_HZ - 1;
    localparam int unsigned PDM_MIN_HZ = 1525;
    localparam int PWM_BITS = 9;
    localparam logic [9:0] DUTY_FULL = 10'h200;
    localparam int NPINS = 3;
    localparam int DIV_W = 25;
    localparam logic [4:0] DIV_STEPS = 5'h18;

    // ==========================================
    // register map
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_CMD = 5'h04;
    localparam logic [4:0] ADDR_SCALE = 5'h08;
    localparam logic [4:0] ADDR_PWM_HZ = 5'h0c;
    localparam logic [4:0] ADDR_PDM_HZ = 5'h10;
    localparam logic [4:0] ADDR_PIN_CFG = 5'h14;
    localparam logic [4:0] ADDR_STATUS = 5'h18;

    // ==========================================
    // fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_FMT_LSB = 4;
    localparam int CFG_INV_LSB = 0;
    localparam int CFG_OD_LSB = 4;
    localparam int CFG_DRV_LSB = 8;
    localparam int ST_MAG_LSB = 0;
    localparam int ST_NEG_BIT = 12;
    localparam int ST_BUSY_BIT = 13;
    localparam int ST_PIN_LSB = 16;
    localparam int ST_PINN_LSB = 20;

    // ==========================================
    // types and reset values
    typedef enum logic [2:0] {
        FMT_NONE = 3'h0,
        FMT_PWM_DIR = 3'h1,
        FMT_UP_DOWN = 3'h2,
        FMT_PDM_DIR = 3'h3,
        FMT_DIR_PWM = 3'h4
    } pwg_fmt_t;

    localparam logic [15:0] SCALE_RST = 16'h0001;
    localparam logic [31:0] PWM_HZ_RST = 32'h0000_4e20;
    localparam logic [31:0] PDM_HZ_RST = 32'h000f_4240;
    localparam logic [2:0] DRV_RST = 3'h7;

    typedef struct packed {
        logic en;
        pwg_fmt_t fmt;
        logic [15:0] cmd;
        logic [15:0] scale;
        logic [31:0] pwm_hz;
        logic [31:0] pdm_hz;
        logic [2:0] inv;
        logic [2:0] od;
        logic [2:0] drv;
        logic [31:0] pwm_acc;
        logic [31:0] pdm_acc;
        logic [8:0] cnt;
        logic [9:0] dacc;
        logic pdm_bit;
        logic [9:0] mag;
        logic neg;
        logic busy;
        logic sneg;
        logic szero;
        logic inh;
        logic o0;
        logic o1;
        logic [31:0] rdata;
    } pwg_top_st_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic [4:0] cnt;
        logic [16:0] rem;
        logic [DIV_W-1:0] dq;
        logic [15:0] dvs;
    } pwg_div_st_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic o;
        logic oe;
    } pwg_pin_st_t;

endpackage

// ===== pkg/pwg_div_if.sv
`timescale 1ns/1ps
interface pwg_div_if;
    logic start;
    logic [24:0] dividend;
    logic [15:0] divisor;
    logic done;
    logic [24:0] quotient;
    modport req (output start, output dividend, output divisor,
        input done, input quotient);
    modport div (input start, input dividend, input divisor,
        output done, output quotient);
endinterface

// ===== hw/pwg_divider.sv
`timescale 1ns/1ps
module pwg_divider
    import pwg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    pwg_div_if.div dv
);
    pwg_div_st_t st_q;
    pwg_div_st_t st_d;
    logic [16:0] r;

    // ==========================================
    // restoring divider, one bit per clock
    always_comb begin
        st_d = st_q;
        r = '0;
        st_d.done = 1'b0;
        if (!st_q.busy) begin
            if (dv.start) begin
                st_d.busy = 1'b1;
                st_d.cnt = DIV_STEPS;
                st_d.rem = '0;
                st_d.dq = dv.dividend;
                st_d.dvs = dv.divisor;
            end
        end else begin
            r = {st_q.rem[15:0], st_q.dq[DIV_W-1]};
            if (r >= {1'b0, st_q.dvs}) begin
                st_d.rem = r - {1'b0, st_q.dvs};
                st_d.dq = {st_q.dq[DIV_W-2:0], 1'b1};
            end else begin
                st_d.rem = r;
                st_d.dq = {st_q.dq[DIV_W-2:0], 1'b0};
            end
            st_d.cnt = st_q.cnt - 5'h01;
            if (st_q.cnt == 5'h00) begin
                st_d.busy = 1'b0;
                st_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dv.done = st_q.done;
    assign dv.quotient = st_q.dq;
endmodule

// ===== hw/pwg_pin_stage.sv
`timescale 1ns/1ps
module pwg_pin_stage
    import pwg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic val,
    input wire logic invert,
    input wire logic pin_drive_select,
    input wire logic open_drain_select,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe,
    output logic pin_in
);
    pwg_pin_st_t st_q;
    pwg_pin_st_t st_d;
    logic v;

    // ==========================================
    // inversion, drive mode and input sync
    always_comb begin
        st_d = st_q;
        v = val ^ invert; // [RULE16]
        st_d.s1 = pin_i;
        st_d.s2 = st_q.s1; // [RULE20]
        st_d.o = open_drain_select ? 1'b0 : v; // [RULE18] [RULE19]
        st_d.oe = pin_drive_select & (~open_drain_select | ~v);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_o = st_q.o;
    assign pin_oe = st_q.oe;
    assign pin_in = st_q.s2;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    push_pull_a: assert property ( // [RULE18]
        pin_drive_select && !open_drain_select
        |=> pin_oe && pin_o == $past(val ^ invert))
        else $error("push-pull pin not driven to its value");
    open_drain_a: assert property ( // [RULE19]
        pin_drive_select && open_drain_select
        |=> !pin_o && (pin_oe == !$past(val ^ invert)))
        else $error("open-drain pin level wrong");
    pin_invert_a: assert property ( // [RULE16]
        pin_drive_select && !open_drain_select && invert
        |=> pin_o != $past(val))
        else $error("inverted pin carries plain value");
endmodule

// ===== hw/pwg_top.sv
`timescale 1ns/1ps
// Functional notes
// [RULE1] enabled: inhibit output low, modulated signals produced
// [RULE2] disabled: inhibit output high, both signal outputs held low
// [RULE3] three pins per instance: inhibit, first and second signal
// [RULE4] format 1: pulse width on first, direction on second
// [RULE5] format 2: up pulses on first, down pulses on second
// [RULE6] format 3: density stream on first, direction on second
// [RULE7] format 4: direction on first, pulse width on second
// [RULE8] format may change while running; outputs follow at once
// [RULE9] duty is command over scale, clipped to -1..+1
// [RULE10] density mode decides pulse or space once per slot
// [RULE11] slot frequency from about 1525 Hz to just under clock
// [RULE12] one slot frequency shared by all density instances
// [RULE13] one pulse frequency shared by pulse-width formats
// [RULE14] pulse frequency 1 Hz up to clock-scaled maximum
// [RULE15] requested frequency above maximum clipped to maximum
// [RULE16] inversion makes the pin carry the inverse value
// [RULE17] software inverts via the pin setting, not the generator
// [RULE18] push-pull pin driven at both levels
// [RULE19] open-drain: 0 drives low, 1 releases the pin
// [RULE20] released pin level readable as true and inverted input
// [RULE21] duty sign gives direction, magnitude gives high time
// [RULE22] up/down: only one output pulses, per sign of duty
module pwg_top
    import pwg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [4:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [NPINS-1:0] pin_i,
    output logic [NPINS-1:0] pin_o,
    output logic [NPINS-1:0] pin_oe
);
    pwg_top_st_t st_q;
    pwg_top_st_t st_d;
    pwg_div_if dif ();
    logic [NPINS-1:0] pin_in;
    logic [NPINS-1:0] pin_val;
    logic [15:0] cmd_abs;
    logic pwm_w;
    logic [1:0] route_w;
    logic [31:0] pwm_sum;
    logic [31:0] pdm_sum;
    logic [9:0] dsum;

    // ==========================================
    // helpers
    function automatic logic [31:0] clip_hz(
        input logic [31:0] v,
        input logic [31:0] lo,
        input logic [31:0] hi
    );
        logic [31:0] r;
        r = v;
        if (v > hi) begin
            r = hi;
        end
        if (v < lo) begin
            r = lo;
        end
        return r;
    endfunction

    function automatic logic [1:0] route(
        input pwg_fmt_t f,
        input logic pw,
        input logic pd,
        input logic dir
    );
        logic [1:0] r;
        r = 2'h0;
        case (f)
            FMT_PWM_DIR: begin
                r = {dir, pw}; // [RULE4] [RULE21]
            end
            FMT_UP_DOWN: begin
                r = {pw & dir, pw & ~dir}; // [RULE5] [RULE22]
            end
            FMT_PDM_DIR: begin
                r = {dir, pd}; // [RULE6]
            end
            FMT_DIR_PWM: begin
                r = {pw, dir}; // [RULE7]
            end
            default: begin
                r = 2'h0;
            end
        endcase
        return r;
    endfunction

    // ==========================================
    // duty computation
    assign cmd_abs = st_q.cmd[15] ? 16'(-st_q.cmd) : st_q.cmd;
    assign dif.start = ~st_q.busy;
    assign dif.dividend = {cmd_abs, 9'h000};
    assign dif.divisor = st_q.scale;

    pwg_divider u_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .dv(dif.div)
    );

    // ==========================================
    // shared rate generators
    assign pwm_sum = st_q.pwm_acc + (st_q.pwm_hz << PWM_BITS);
    assign pdm_sum = st_q.pdm_acc + st_q.pdm_hz;
    assign dsum = st_q.dacc + st_q.mag;
    assign pwm_w = {1'b0, st_q.cnt} < st_q.mag; // [RULE21]
    assign route_w = route(st_q.fmt, pwm_w, st_q.pdm_bit, st_q.neg);

    // ==========================================
    // next state
    always_comb begin
        st_d = st_q;
        st_d.rdata = '0;
        if (wr) begin
            case (addr)
                ADDR_CTRL: begin
                    st_d.en = wdata[CTRL_EN_BIT];
                    st_d.fmt = pwg_fmt_t'(wdata[CTRL_FMT_LSB +: 3]); // [RULE8]
                end
                ADDR_CMD: begin
                    st_d.cmd = wdata[15:0];
                end
                ADDR_SCALE: begin
                    st_d.scale = wdata[15:0];
                end
                ADDR_PWM_HZ: begin
                    st_d.pwm_hz = clip_hz(wdata, PWM_MIN_HZ,
                        PWM_MAX_HZ); // [RULE13] [RULE14] [RULE15]
                end
                ADDR_PDM_HZ: begin
                    st_d.pdm_hz = clip_hz(wdata, PDM_MIN_HZ,
                        PDM_MAX_HZ); // [RULE11] [RULE12] [RULE15]
                end
                ADDR_PIN_CFG: begin
                    st_d.inv = wdata[CFG_INV_LSB +: NPINS];
                    st_d.od = wdata[CFG_OD_LSB +: NPINS];
                    st_d.drv = wdata[CFG_DRV_LSB +: NPINS];
                end
                default: begin
                end
            endcase
        end
        if (rd) begin
            case (addr)
                ADDR_CTRL: begin
                    st_d.rdata[CTRL_EN_BIT] = st_q.en;
                    st_d.rdata[CTRL_FMT_LSB +: 3] = st_q.fmt;
                end
                ADDR_CMD: begin
                    st_d.rdata[15:0] = st_q.cmd;
                end
                ADDR_SCALE: begin
                    st_d.rdata[15:0] = st_q.scale;
                end
                ADDR_PWM_HZ: begin
                    st_d.rdata = st_q.pwm_hz;
                end
                ADDR_PDM_HZ: begin
                    st_d.rdata = st_q.pdm_hz;
                end
                ADDR_PIN_CFG: begin
                    st_d.rdata[CFG_INV_LSB +: NPINS] = st_q.inv;
                    st_d.rdata[CFG_OD_LSB +: NPINS] = st_q.od;
                    st_d.rdata[CFG_DRV_LSB +: NPINS] = st_q.drv;
                end
                ADDR_STATUS: begin
                    st_d.rdata[ST_MAG_LSB +: 10] = st_q.mag;
                    st_d.rdata[ST_NEG_BIT] = st_q.neg;
                    st_d.rdata[ST_BUSY_BIT] = st_q.busy;
                    st_d.rdata[ST_PIN_LSB +: NPINS] = pin_in; // [RULE20]
                    st_d.rdata[ST_PINN_LSB +: NPINS] = ~pin_in;
                end
                default: begin
                end
            endcase
        end

        // duty: divide, then clip magnitude to full scale
        if (!st_q.busy) begin
            st_d.busy = 1'b1;
            st_d.sneg = st_q.cmd[15];
            st_d.szero = st_q.cmd == 16'h0000;
        end
        if (dif.done) begin
            st_d.busy = 1'b0;
            st_d.neg = st_q.sneg & ~st_q.szero; // [RULE21]
            if (st_q.szero) begin
                st_d.mag = 10'h000;
            end else if (dif.quotient > 25'(DUTY_FULL)) begin
                st_d.mag = DUTY_FULL; // [RULE9]
            end else begin
                st_d.mag = dif.quotient[9:0]; // [RULE9]
            end
        end

        // pulse-width period counter
        if (pwm_sum >= CLK_HZ) begin
            st_d.pwm_acc = pwm_sum - CLK_HZ; // [RULE13]
            st_d.cnt = st_q.cnt + 9'h001;
        end else begin
            st_d.pwm_acc = pwm_sum;
        end

        // density slots
        if (pdm_sum >= CLK_HZ) begin
            st_d.pdm_acc = pdm_sum - CLK_HZ; // [RULE10]
            if (dsum >= DUTY_FULL) begin
                st_d.pdm_bit = 1'b1;
                st_d.dacc = dsum - DUTY_FULL;
            end else begin
                st_d.pdm_bit = 1'b0;
                st_d.dacc = dsum;
            end
        end else begin
            st_d.pdm_acc = pdm_sum;
        end

        // output gating
        if (st_q.en) begin
            st_d.inh = 1'b0; // [RULE1]
            st_d.o0 = route_w[0];
            st_d.o1 = route_w[1];
        end else begin
            st_d.inh = 1'b1; // [RULE2]
            st_d.o0 = 1'b0;
            st_d.o1 = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= '0;
            st_q.fmt <= FMT_PWM_DIR;
            st_q.scale <= SCALE_RST;
            st_q.pwm_hz <= PWM_HZ_RST;
            st_q.pdm_hz <= PDM_HZ_RST;
            st_q.drv <= DRV_RST;
            st_q.inh <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata = st_q.rdata;

    // ==========================================
    // pins: inhibit, first and second signal
    assign pin_val = {st_q.o1, st_q.o0, st_q.inh}; // [RULE3]

    generate
        for (genvar i = 0; i < NPINS; i++) begin : g_pin
            pwg_pin_stage u_pin (
                .clk_sys(clk_sys),
                .rst(rst),
                .val(pin_val[i]),
                .invert(st_q.inv[i]),
                .pin_drive_select(st_q.drv[i]),
                .open_drain_select(st_q.od[i]),
                .pin_i(pin_i[i]),
                .pin_o(pin_o[i]),
                .pin_oe(pin_oe[i]),
                .pin_in(pin_in[i])
            );
        end
    endgenerate

    // ==========================================
    // checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    enable_drive_a: assert property ( // [RULE1]
        st_q.en |=> !st_q.inh)
        else $error("inhibit asserted while enabled");
    disable_quiet_a: assert property ( // [RULE2]
        !st_q.en |=> st_q.inh && !st_q.o0 && !st_q.o1)
        else $error("signals active while disabled");
    fmt_pwm_dir_a: assert property ( // [RULE4]
        st_q.en && st_q.fmt == FMT_PWM_DIR
        |=> st_q.o0 == $past(pwm_w) && st_q.o1 == $past(st_q.neg))
        else $error("format 1 routing wrong");
    fmt_up_down_a: assert property ( // [RULE5]
        st_q.en && st_q.fmt == FMT_UP_DOWN
        |=> st_q.o0 == $past(pwm_w && !st_q.neg)
            && st_q.o1 == $past(pwm_w && st_q.neg))
        else $error("format 2 routing wrong");
    fmt_pdm_dir_a: assert property ( // [RULE6]
        st_q.en && st_q.fmt == FMT_PDM_DIR
        |=> st_q.o0 == $past(st_q.pdm_bit)
            && st_q.o1 == $past(st_q.neg))
        else $error("format 3 routing wrong");
    fmt_dir_pwm_a: assert property ( // [RULE7]
        st_q.en && st_q.fmt == FMT_DIR_PWM
        |=> st_q.o1 == $past(pwm_w) && st_q.o0 == $past(st_q.neg))
        else $error("format 4 routing wrong");
    fmt_change_a: assert property ( // [RULE8]
        wr && addr == ADDR_CTRL && wdata[CTRL_EN_BIT]
        && wdata[CTRL_FMT_LSB +: 3] == FMT_DIR_PWM
        |=> ##1 st_q.o0 == $past(st_q.neg))
        else $error("outputs ignore new format");
    duty_clip_a: assert property ( // [RULE9]
        st_q.mag <= DUTY_FULL)
        else $error("duty magnitude above full scale");
    slot_hold_a: assert property ( // [RULE10]
        pdm_sum < CLK_HZ |=> $stable(st_q.pdm_bit) && $stable(st_q.dacc))
        else $error("density decision outside a slot");
    freq_clip_a: assert property ( // [RULE15]
        st_q.pwm_hz <= PWM_MAX_HZ && st_q.pdm_hz <= PDM_MAX_HZ
        && st_q.pwm_hz >= PWM_MIN_HZ && st_q.pdm_hz >= PDM_MIN_HZ)
        else $error("frequency setting out of range");
    up_down_excl_a: assert property ( // [RULE22]
        st_q.fmt == FMT_UP_DOWN |-> !(st_q.o0 && st_q.o1))
        else $error("up and down active together");
endmodule

// ===== bench/pwg_amp_model.sv
`timescale 1ns/1ps
// ==========================================
// power stage: weak pull-up on every line
module pwg_amp_model (
    input wire logic [2:0] pin_o,
    input wire logic [2:0] pin_oe,
    input wire logic [2:0] ext_low,
    output logic [2:0] pin_wire
);
    // released line floats high unless the stage pulls it low
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_wire[i] = pin_oe[i] ? pin_o[i] : ~ext_low[i];
        end
    end
endmodule

// ===== bench/pwg_top_tb_top.sv
`timescale 1ns/1ps
module pwg_top_tb_top
    import pwg_pkg::*;
;
    logic clk_sys;
    logic rst;
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] v;
    logic [2:0] pin_o;
    logic [2:0] pin_oe;
    logic [2:0] pin_wire;
    logic [2:0] ext_low;
    int fail_count;
    int tests_run;

    pwg_top DUT (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .pin_i(pin_wire), .pin_o(pin_o),
        .pin_oe(pin_oe));
    pwg_amp_model amp (.pin_o(pin_o), .pin_oe(pin_oe), .ext_low(ext_low),
        .pin_wire(pin_wire));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ==========================================
    // helpers
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic near(input int got, input int exp, input int tol);
        check({31'h0, (got + tol >= exp) && (got <= exp + tol)}, 32'h1);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic measure(input int n, output int h1, output int h2);
        h1 = 0;
        h2 = 0;
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            h1 += int'(pin_wire[1]);
            h2 += int'(pin_wire[2]);
        end
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset;
        logic [4:0] ra[7];
        logic [31:0] rv[7];
        ra = '{ADDR_CTRL, ADDR_CMD, ADDR_SCALE, ADDR_PWM_HZ, ADDR_PDM_HZ,
            ADDR_PIN_CFG, 5'h1c};
        rv = '{32'h10, 32'h0, 32'h1, PWM_HZ_RST, PDM_HZ_RST, 32'h700, 32'h0};
        cyc(1);
        #1;
        check(32'(pin_oe), 32'h7);
        check(32'(pin_wire), 32'h1);
        for (int i = 0; i < 7; i++) begin
            rd_reg(ra[i], v);
            check(v, rv[i]);
        end
    endtask

    task automatic t_freq;
        wr_reg(ADDR_PWM_HZ, 32'hffffffff);
        rd_reg(ADDR_PWM_HZ, v);
        check(v, PWM_MAX_HZ);
        wr_reg(ADDR_PWM_HZ, 32'h0);
        rd_reg(ADDR_PWM_HZ, v);
        check(v, PWM_MIN_HZ);
        wr_reg(ADDR_PDM_HZ, 32'h0);
        rd_reg(ADDR_PDM_HZ, v);
        check(v, PDM_MIN_HZ);
        wr_reg(ADDR_PDM_HZ, 32'hffffffff);
        rd_reg(ADDR_PDM_HZ, v);
        check(v, PDM_MAX_HZ);
        wr_reg(ADDR_PWM_HZ, 32'hffffffff);
    endtask

    task automatic t_duty;
        logic [31:0] cmd[3];
        logic [31:0] st[3];
        cmd = '{32'h32, 32'h12c, 32'hfed4};
        st = '{32'h100, 32'h200, 32'h1200};
        wr_reg(ADDR_SCALE, 32'h64);
        for (int i = 0; i < 3; i++) begin
            wr_reg(ADDR_CMD, cmd[i]);
            cyc(64);
            rd_reg(ADDR_STATUS, v);
            check(32'(v[12:0]), st[i]);
        end
    endtask

    task automatic t_formats;
        int n;
        int h1;
        int h2;
        int pw;
        int dv;
        int e1;
        int e2;
        n = 2072;
        pw = n / 4;
        for (int s = 0; s < 2; s++) begin
            wr_reg(ADDR_CMD, (s == 1) ? 32'hffe7 : 32'h19);
            cyc(64);
            dv = (s == 1) ? n : 0;
            for (int f = 1; f < 5; f++) begin
                // format changed while running, never disabled
                wr_reg(ADDR_CTRL, 32'((f << 4) | 1));
                cyc(8);
                #1;
                check(32'(pin_wire[0]), 32'h0);
                measure(n, h1, h2);
                e1 = (f == 4) ? dv : pw;
                e2 = (f == 4) ? pw : dv;
                if (f == 2) begin
                    e1 = (s == 1) ? 0 : pw;
                    e2 = (s == 1) ? pw : 0;
                end
                near(h1, e1, (e1 == 0 || e1 == n) ? 0 : n / 32);
                near(h2, e2, (e2 == 0 || e2 == n) ? 0 : n / 32);
            end
        end
    endtask

    task automatic t_disable;
        int h1;
        int h2;
        wr_reg(ADDR_CTRL, 32'h10);
        cyc(4);
        #1;
        check(32'(pin_wire), 32'h1);
        measure(600, h1, h2);
        check(32'(h1 + h2), 32'h0);
    endtask

    task automatic t_pins;
        // inversion is set on the pin stage, not the generator
        wr_reg(ADDR_PIN_CFG, 32'h707);
        cyc(4);
        #1;
        check(32'(pin_wire), 32'h6);
        check(32'(pin_oe), 32'h7);
        wr_reg(ADDR_PIN_CFG, 32'h770);
        cyc(4);
        #1;
        check(32'(pin_oe), 32'h6);
        check(32'(pin_o[2:1]), 32'h0);
        check(32'(pin_wire), 32'h1);
        ext_low <= 3'h1;
        cyc(6);
        rd_reg(ADDR_STATUS, v);
        check(32'(v[22:16]), 32'h70);
        ext_low <= 3'h0;
        cyc(6);
        rd_reg(ADDR_STATUS, v);
        check(32'(v[22:16]), 32'h61);
        wr_reg(ADDR_PIN_CFG, 32'h700);
    endtask

    // ==========================================
    // main sequence and watchdog
    initial begin
        fail_count = 0;
        tests_run = 0;
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 5'h00;
        wdata = 32'h0;
        ext_low = 3'h0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_freq();
        t_duty();
        t_formats();
        t_disable();
        t_pins();
        finish_test();
    end

    initial begin
        #4_000_000;
        fail_count++;
        finish_test();
    end
endmodule
